/* File: verilog/ascc_top.sv */
`include "ascc_cfg.svh"

module ascc_top
    import ascc_pkg::*;
#(
    parameter bit P_EIGHT_CHANNELS = 1'b1
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    // Serial port
    input wire logic I_FS_B,
    input wire logic I_SCLK,
    input wire logic I_SDI,
    output logic O_SDO,
    output logic O_SDO_OE,
    // Multipurpose status pin
    input wire logic I_STATUS_PIN,
    output logic O_STATUS_PIN,
    output logic O_STATUS_PIN_OE,
    // Conversion start pin, active low
    input wire logic I_CONVERSION_START_PIN_B,
    // Conversion engine side
    input wire logic [15:0] I_CONV_DATA,
    input wire logic [2:0] I_CONV_TAG,
    input wire logic I_CONV_DONE,
    input wire logic I_CONV_INT,
    output ascc_cfg_type O_CONFIG,
    output logic [2:0] O_CHANNEL,
    output logic O_AUTO_NAP_EN,
    output logic O_NAP_PD,
    output logic O_DEEP_PD,
    output logic [5:0] O_START_SPACING,
    output logic O_CONV_START,
    output logic O_CONVERSION_CLOCK_SERIAL,
    output logic O_WAKE,
    output logic O_SOFT_RESET
);

    logic rst_b;
    ascc_state_type state_reg, state_next;
    logic fs_prev_reg, fs_prev_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic cvs_prev_reg, cvs_prev_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [15:0] in_reg, in_next;
    logic [23:0] out_reg, out_next;
    logic [3:0] op_reg, op_next;
    ascc_cfg_type cfg_reg, cfg_next;
    logic [2:0] chan_reg, chan_next;
    logic post_rst_reg, post_rst_next;
    logic wake_reg, wake_next;
    logic swrst_reg, swrst_next;
    logic start_reg, start_next;
    logic div_reg, div_next;
    logic stat_reg, stat_next;
    logic fs_fall, fs_rise, sclk_fall;
    logic [4:0] cnt_inc;
    logic [15:0] in_shift;
    logic [23:0] out_shift;
    logic [3:0] op_now;
    logic fill;

    ascc_rst_sync u_rst_sync (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .o_rst_b(rst_b)
    );

    // Pins are synchronous to the clock, so edges are taken from one stored copy.
    assign fs_fall = fs_prev_reg & ~I_FS_B;
    assign fs_rise = ~fs_prev_reg & I_FS_B;
    assign sclk_fall = sclk_prev_reg & ~I_SCLK;
    assign cnt_inc = cnt_reg + 5'h 01;
    assign in_shift = {in_reg[14:0], I_SDI};
    assign op_now = in_shift[3:0];
    assign fill = cfg_reg.stat_out ? 1'b0 : I_STATUS_PIN;

    // Without tags the chain bit enters behind the 16 data bits, with tags behind 24.
    always_comb begin
        out_shift = {out_reg[22:0], 1'b0};
        if (cfg_reg.tag_en) begin
            out_shift[0] = fill;
        end else begin
            out_shift[8] = fill;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        in_next = in_reg;
        out_next = out_reg;
        op_next = op_reg;
        cfg_next = cfg_reg;
        chan_next = chan_reg;
        post_rst_next = post_rst_reg;
        wake_next = 1'b0;
        swrst_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (fs_fall) begin
                    state_next = ST_FRAME;
                    cnt_next = 5'h 00;
                    in_next = 16'h 0000;
                    op_next = `ASCC_OP_RD_DATA;
                    post_rst_next = 1'b0;
                    if (post_rst_reg) begin
                        out_next = 24'h FF_FFFF;
                    end else begin
                        out_next = {I_CONV_DATA, cfg_reg.tag_en ? I_CONV_TAG : 3'h 0, 5'h 00};
                    end
                end
            end
            ST_FRAME: begin
                if (fs_rise) begin
                    state_next = ST_IDLE;
                end else if (sclk_fall) begin
                    // The counter saturates so long frames never wrap into a new opcode.
                    if (cnt_reg != `ASCC_MAX_EDGES) begin
                        cnt_next = cnt_inc;
                    end
                    in_next = in_shift;
                    out_next = out_shift;
                    if (cnt_inc == `ASCC_OP_EDGES) begin
                        op_next = op_now;
                        if (!op_now[3]) begin
                            if (P_EIGHT_CHANNELS || !op_now[2]) begin
                                chan_next = op_now[2:0];
                                wake_next = 1'b1;
                            end
                        end else begin
                            case (op_now)
                                `ASCC_OP_WAKE: begin
                                    cfg_next.nap_off = 1'b1;
                                    cfg_next.deep_off = 1'b1;
                                    wake_next = 1'b1;
                                end
                                `ASCC_OP_RD_CFG: begin
                                    // The four data MSBs have already left, so the word restarts at the configuration.
                                    out_next = {cfg_reg, 12'h 000};
                                end
                                `ASCC_OP_RD_DATA: begin
                                    // The result loaded at frame start simply keeps shifting out.
                                    op_next = op_now;
                                end
                                `ASCC_OP_DEFAULT: begin
                                    cfg_next = `ASCC_CFG_RESET;
                                    wake_next = 1'b1;
                                end
                                default: begin
                                    op_next = op_now;
                                end
                            endcase
                        end
                    end
                    if (cnt_inc == `ASCC_WORD_EDGES && op_reg == `ASCC_OP_WR_CFG) begin
                        if (!in_shift[0]) begin
                            cfg_next = `ASCC_CFG_RESET;
                            swrst_next = 1'b1;
                            post_rst_next = 1'b1;
                        end else begin
                            cfg_next = in_shift[11:0];
                        end
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        fs_prev_next = I_FS_B;
        sclk_prev_next = I_SCLK;
        cvs_prev_next = I_CONVERSION_START_PIN_B;
        start_next = cfg_reg.man_trig & cvs_prev_reg & ~I_CONVERSION_START_PIN_B;
        div_next = div_reg;
        if (!cfg_reg.conversion_clock_int && sclk_fall) begin
            div_next = ~div_reg;
        end
        stat_next = (cfg_reg.stat_eoc ? I_CONV_DONE : I_CONV_INT) ^ cfg_reg.stat_low;
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            fs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b1;
            cvs_prev_reg <= 1'b1;
            cnt_reg <= 5'h 00;
            in_reg <= 16'h 0000;
            out_reg <= 24'h FF_FFFF;
            op_reg <= `ASCC_OP_RD_DATA;
            cfg_reg <= `ASCC_CFG_RESET;
            chan_reg <= 3'h 0;
            post_rst_reg <= 1'b1;
            wake_reg <= 1'b0;
            swrst_reg <= 1'b0;
            start_reg <= 1'b0;
            div_reg <= 1'b0;
            stat_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fs_prev_reg <= fs_prev_next;
            sclk_prev_reg <= sclk_prev_next;
            cvs_prev_reg <= cvs_prev_next;
            cnt_reg <= cnt_next;
            in_reg <= in_next;
            out_reg <= out_next;
            op_reg <= op_next;
            cfg_reg <= cfg_next;
            chan_reg <= chan_next;
            post_rst_reg <= post_rst_next;
            wake_reg <= wake_next;
            swrst_reg <= swrst_next;
            start_reg <= start_next;
            div_reg <= div_next;
            stat_reg <= stat_next;
        end
    end

    assign O_SDO = out_reg[23];
    assign O_SDO_OE = (state_reg == ST_FRAME);
    assign O_STATUS_PIN = stat_reg;
    assign O_STATUS_PIN_OE = cfg_reg.stat_out;
    assign O_CONFIG = cfg_reg;
    assign O_CHANNEL = chan_reg;
    // Doze cannot save power at the fast automatic rate, so it is held off there.
    assign O_AUTO_NAP_EN = ~cfg_reg.anap_off & (cfg_reg.man_trig | cfg_reg.rate_250k);
    assign O_NAP_PD = ~cfg_reg.nap_off;
    assign O_DEEP_PD = ~cfg_reg.deep_off;
    assign O_START_SPACING = cfg_reg.rate_250k ? `ASCC_SPACE_250K : `ASCC_SPACE_500K;
    assign O_CONV_START = start_reg;
    assign O_CONVERSION_CLOCK_SERIAL = div_reg;
    assign O_WAKE = wake_reg;
    assign O_SOFT_RESET = swrst_reg;

endmodule

/* File: pkg/ascc_cfg.svh */
`ifndef ASCC_CFG_SVH
`define ASCC_CFG_SVH

// Opcodes held in the upper nibble of a frame.
`define ASCC_OP_WAKE 4'h B
`define ASCC_OP_RD_CFG 4'h C
`define ASCC_OP_RD_DATA 4'h D
`define ASCC_OP_WR_CFG 4'h E
`define ASCC_OP_DEFAULT 4'h F

// Configuration word layout and reset value.
`define ASCC_CFG_W 12
`define ASCC_CFG_RESET 12'h 0FFF
`define ASCC_BIT_NAP 3
`define ASCC_BIT_DEEP 2

// Frame bit counts.
`define ASCC_OP_EDGES 5'h 04
`define ASCC_WORD_EDGES 5'h 10
`define ASCC_MAX_EDGES 5'h 18

// Auto-trigger start spacing in conversion clocks.
`define ASCC_SPACE_500K 6'h 15
`define ASCC_SPACE_250K 6'h 2A

`endif

/* File: pkg/ascc_pkg.sv */
package ascc_pkg;

    // Configuration word, most significant field first.
    typedef struct packed {
        logic auto_chan;
        logic conversion_clock_int;
        logic man_trig;
        logic rate_250k;
        logic stat_low;
        logic stat_eoc;
        logic stat_out;
        logic anap_off;
        logic nap_off;
        logic deep_off;
        logic tag_en;
        logic run;
    } ascc_cfg_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FRAME = 1'b1
    } ascc_state_type;

endpackage

/* File: verilog/ascc_rst_sync.sv */
module ascc_rst_sync (
    // Clock and raw reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Released reset
    output logic o_rst_b
);

    logic meta_reg;
    logic hold_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            hold_reg <= meta_reg;
        end
    end

    assign o_rst_b = hold_reg;

endmodule

/* File: verif/ascc_monitor.sv */
module ascc_monitor
    import ascc_pkg::*;
(
    // Clock, reset and pins driven from outside
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic I_FS_B,
    input wire logic I_SCLK,
    input wire logic I_CONVERSION_START_PIN_B,
    input wire logic I_CONV_DONE,
    input wire logic I_CONV_INT,
    // Outputs of the block
    input wire logic O_SDO_OE,
    input wire logic O_STATUS_PIN,
    input wire logic O_STATUS_PIN_OE,
    input wire ascc_cfg_type O_CONFIG,
    input wire logic [2:0] O_CHANNEL,
    input wire logic O_AUTO_NAP_EN,
    input wire logic O_NAP_PD,
    input wire logic O_DEEP_PD,
    input wire logic [5:0] O_START_SPACING,
    input wire logic O_CONV_START,
    input wire logic O_CONVERSION_CLOCK_SERIAL,
    input wire logic O_WAKE,
    input wire logic O_SOFT_RESET
);
    timeunit 1ns;
    timeprecision 1ns;
    // Checks wait out the reset synchroniser so that history from reset is never judged.
    logic [3:0] up_reg;
    logic [3:0] up_next;
    always_comb up_next = {up_reg[2:0], 1'b1};
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            up_reg <= 4'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    default clocking @(posedge I_MCLK);
    endclocking
    default disable iff (!up_reg[3]);
    sequence s_frame_open;
        $fell(I_FS_B);
    endsequence
    sequence s_start_edge;
        $fell(I_CONVERSION_START_PIN_B) && O_CONFIG.man_trig;
    endsequence
    a_oe_on_open: assert property (s_frame_open |=> O_SDO_OE)
        else $error("serial output not enabled after frame open");
    a_oe_off_idle: assert property (I_FS_B |=> !O_SDO_OE)
        else $error("serial output driven outside a frame");
    a_wake_pulse: assert property (O_WAKE |=> !O_WAKE)
        else $error("wake pulse longer than one cycle");
    a_chan_with_wake: assert property ($changed(O_CHANNEL) |-> O_WAKE)
        else $error("channel changed without a wake pulse");
    a_soft_to_default: assert property (O_SOFT_RESET |-> ##[0:1] (O_CONFIG == 12'hFFF))
        else $error("software reset did not load all ones");
    a_doze_gate: assert property (O_AUTO_NAP_EN ==
        (!O_CONFIG.anap_off && (O_CONFIG.man_trig || O_CONFIG.rate_250k)))
        else $error("doze enable wrong");
    a_pd_bits: assert property (O_NAP_PD == !O_CONFIG.nap_off && O_DEEP_PD == !O_CONFIG.deep_off)
        else $error("power-down outputs wrong");
    a_spacing: assert property (O_START_SPACING == (O_CONFIG.rate_250k ? 6'h2A : 6'h15))
        else $error("start spacing wrong");
    a_pin_dir: assert property (O_STATUS_PIN_OE == O_CONFIG.stat_out)
        else $error("status pin direction wrong");
    a_status_level: assert property (O_STATUS_PIN ==
        (($past(O_CONFIG.stat_eoc) ? $past(I_CONV_DONE) : $past(I_CONV_INT)) ^ $past(O_CONFIG.stat_low)))
        else $error("status pin level wrong");
    a_start_pulse: assert property (s_start_edge |-> ##[1:2] O_CONV_START)
        else $error("no conversion start after start pin fall");
    a_conversion_clock_divide: assert property (($fell(I_SCLK) && !O_CONFIG.conversion_clock_int) |=> $changed(O_CONVERSION_CLOCK_SERIAL))
        else $error("serial conversion clock did not toggle on clock fall");
    a_conversion_clock_hold: assert property (O_CONFIG.conversion_clock_int |=> $stable(O_CONVERSION_CLOCK_SERIAL))
        else $error("serial conversion clock moved while oscillator selected");
endmodule

bind ascc_top ascc_monitor u_ascc_monitor (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_FS_B(I_FS_B),
    .I_SCLK(I_SCLK), .I_CONVERSION_START_PIN_B(I_CONVERSION_START_PIN_B), .I_CONV_DONE(I_CONV_DONE), .I_CONV_INT(I_CONV_INT),
    .O_SDO_OE(O_SDO_OE), .O_STATUS_PIN(O_STATUS_PIN), .O_STATUS_PIN_OE(O_STATUS_PIN_OE),
    .O_CONFIG(O_CONFIG), .O_CHANNEL(O_CHANNEL), .O_AUTO_NAP_EN(O_AUTO_NAP_EN), .O_NAP_PD(O_NAP_PD),
    .O_DEEP_PD(O_DEEP_PD), .O_START_SPACING(O_START_SPACING), .O_CONV_START(O_CONV_START),
    .O_CONVERSION_CLOCK_SERIAL(O_CONVERSION_CLOCK_SERIAL), .O_WAKE(O_WAKE), .O_SOFT_RESET(O_SOFT_RESET));

/* File: verif/ascc_host.sv */
module ascc_host (
    // Clock and returned serial data
    input wire logic i_clk,
    input wire logic i_sdo,
    // Serial bus toward the device
    output logic o_fs_b,
    output logic o_sclk,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_fs_b = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b0;
    end
    // Each serial clock half lasts two system cycles, so every edge is seen.
    task automatic half(input logic s);
        o_sclk <= s;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic frame(input logic [15:0] tx, input int n, output logic [23:0] rx);
        logic [23:0] sr;
        sr = {tx, 8'h00};
        rx = 24'h00_0000;
        o_fs_b <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_sdi <= sr[23];
            half(1'b1);
            rx[23 - i] = i_sdo;
            sr = sr << 1;
            half(1'b0);
        end
        half(1'b1);
        o_fs_b <= 1'b1;
        // The released data line flips so a stale bit can never look valid.
        o_sdi <= ~o_sdi;
        half(1'b1);
    endtask
endmodule

/* File: verif/tb_adc_serial_command_config.sv */
module tb_adc_serial_command_config import ascc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic fs_b, sclk, sdi, sdo, sdo_oe, st_out, st_oe, nap_pd, deep_pd;
    logic [15:0] data = 16'h0000;
    logic [2:0] tag = 3'h0;
    logic [2:0] chan;
    logic [11:0] cfg;
    logic [23:0] rx;
    logic [31:0] seed = 32'h7ea0_5bb0;
    logic [31:0] bg = 32'h0000_0003;
    logic [31:0] cyc = 32'h0000_0000;
    int bad_count = 0;
    int compares = 0;
    ascc_cfg_type conf;
    wire st_pin = st_oe ? st_out : bg[5];
    // A released serial line shows the inverse, so a bit taken outside the enable window reads wrong.
    wire sdo_pin = sdo_oe ? sdo : ~sdo;
    ascc_top u_ascc_top (.I_MCLK(mclk), .I_RST_B(rst_b), .I_FS_B(fs_b), .I_SCLK(sclk), .I_SDI(sdi),
        .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_STATUS_PIN(st_pin), .O_STATUS_PIN(st_out),
        .O_STATUS_PIN_OE(st_oe), .I_CONVERSION_START_PIN_B(bg[0] | bg[1]), .I_CONV_DATA(data), .I_CONV_TAG(tag),
        .I_CONV_DONE(bg[2]), .I_CONV_INT(bg[3]), .O_CONFIG(conf), .O_CHANNEL(chan),
        .O_AUTO_NAP_EN(), .O_NAP_PD(nap_pd), .O_DEEP_PD(deep_pd), .O_START_SPACING(),
        .O_CONV_START(), .O_CONVERSION_CLOCK_SERIAL(), .O_WAKE(), .O_SOFT_RESET());
    ascc_host u_ascc_host (.i_clk(mclk), .i_sdo(sdo_pin), .o_fs_b(fs_b), .o_sclk(sclk), .o_sdi(sdi));
    initial begin
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Only the first n bits are clocked out; trailing bits are expected as zero.
    function automatic logic [23:0] exp_rx(input logic [3:0] op, input logic [11:0] c, input int n);
        logic [23:0] v;
        v = (op == 4'hC) ? {data[15:12], c, 8'h00} : {data, c[1] ? tag : 3'h0, 5'h00};
        return v & ~(24'hFF_FFFF >> n);
    endfunction
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(input logic [15:0] w, input int n);
        seed = xs(seed);
        data = seed[15:0];
        tag = seed[18:16];
        u_ascc_host.frame(w, n, rx);
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(negedge mclk) begin
        bg <= xs(cyc ^ 32'h7ea0_5bb0);
    end
    always @(posedge mclk) begin
        cyc <= cyc + 32'h0000_0001;
        if (cyc == 32'h0000_2000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        run(16'hD000, 16);
        chk("first frame", 24'hFF_FF00, rx);
        chk("reset config", 24'h00_0FFF, {12'h000, conf});
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            cfg = seed[11:0] | 12'h021;
            run({4'hE, cfg}, 16);
            chk("write", {12'h000, cfg}, {12'h000, conf});
            run(16'hC000, 16);
            chk("readback", exp_rx(4'hC, cfg, 16), rx);
            run(16'hD000, 24);
            chk("data", exp_rx(4'hD, cfg, 24), rx);
        end
        run({4'hE, 12'hFF3}, 16);
        chk("power down", 24'h00_0003, {22'h00_0000, nap_pd, deep_pd});
        run(16'hB000, 4);
        chk("wake", 24'h00_0FFF, {12'h000, conf});
        run({4'hE, 12'h3FF}, 16);
        for (int ch = 0; ch < 8; ch++) begin
            run({1'b0, ch[2:0], seed[11:0]}, 4);
            chk("channel", {21'h00_0000, ch[2:0]}, {21'h00_0000, chan});
            chk("lead bits", exp_rx(4'h0, 12'h3FF, 4), rx);
        end
        for (int op = 8; op < 11; op++) begin
            run({op[3:0], 12'h000}, 16);
            chk("reserved", 24'h00_73FF, {9'h000, chan, conf});
        end
        run(16'hF000, 4);
        chk("default", 24'h00_0FFF, {12'h000, conf});
        run({4'hE, 12'h5A2}, 16);
        chk("soft reset", 24'h00_0FFF, {12'h000, conf});
        run(16'hD000, 16);
        chk("after soft", 24'hFF_FF00, rx);
        run({4'hE, 12'h123}, 16);
        rst_b = 1'b0;
        @(negedge mclk);
        chk("pin reset", 24'h00_0FFF, {12'h000, conf});
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        run(16'hD000, 16);
        chk("after pin reset", 24'hFF_FF00, rx);
        tally_and_finish();
    end
endmodule
